/* design/adh_host.sv */
// Chosen here: the Avalon-MM register port and the address map.
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Control write: ctrl select low, strobe pulse
// - Read result after conversion, strobe low
// - Discard first result on new inverting channel
// - DAC write: conv select low, strobe pulse
// - Loopback enabled by reference bit six
// - Loopback read moves result to DAC
// - Both selects high during device reset
module adh_host
	import adh_pkg::*;
#(
	parameter int CONV_WAIT_CYC = CONV_CYC
) (
	// Clock and reset
	input wire logic core_clk_in,
	input wire logic nrst_in,
	// Avalon-MM slave
	input wire logic [4:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	// Device strobes and selects
	output logic ctrl_select_n_out,
	output logic conv_select_n_out,
	output logic write_strobe_n_out,
	output logic read_strobe_n_out,
	output logic dev_reset_n_out,
	// Device data bus, split three ways
	input wire logic [7:0] bus_data_in,
	output logic [7:0] bus_data_out,
	output logic bus_data_oe_out
);

	// ==========================================================
	// State
	// ==========================================================
	adh_state_t st_q, st_d; // Pin sequencer
	adh_op_t op_q, op_d; // Operation in flight
	logic [TMR_W-1:0] tmr_q, tmr_d; // Phase timer
	logic [7:0] word_q, word_d; // Word being written
	logic [7:0] dout_q, dout_d; // Bus drive value
	logic doe_q, doe_d; // Bus drive enable
	logic csc_n_q, csc_n_d; // Control select pin
	logic csa_n_q, csa_n_d; // Converter select pin
	logic we_n_q, we_n_d; // Write strobe pin
	logic rd_n_q, rd_n_d; // Read strobe pin
	logic rst_n_q, rst_n_d; // Device reset pin
	logic [7:0] result_q, result_d; // Last kept result
	logic res_valid_q, res_valid_d; // Fresh result waiting
	logic [7:0] res_cnt_q, res_cnt_d; // Results kept so far
	logic discard_q, discard_d; // Next read is thrown away
	logic disc_en_q, disc_en_d; // Discard feature on
	logic [2:0] last_chan_q, last_chan_d; // Channel last selected
	logic chan_ok_q, chan_ok_d; // Last channel known
	logic loop_q, loop_d; // Device loopback shadow
	logic [7:0] range_sh_q, range_sh_d; // Device range register copy
	logic [7:0] ref_sh_q, ref_sh_d; // Device reference register copy
	logic [7:0] dac_sh_q, dac_sh_d; // Device DAC register copy
	logic ack_q, ack_d; // Bus access taken this cycle
	logic wait_q, wait_d; // Registered waitrequest
	logic [31:0] rdata_q, rdata_d; // Registered read data
	logic [7:0] rx_data; // Synchronised bus input
	logic cmd; // Accepted write this cycle
	logic new_inv; // New inverting channel chosen

	// ==========================================================
	// Input synchroniser
	// ==========================================================
	adh_sync2 #(.WIDTH(8)) u_rx_sync (
		.core_clk_in(core_clk_in),
		.nrst_in(nrst_in),
		.async_in(bus_data_in),
		.sync_out(rx_data)
	);

	assign cmd = ack_q & avs_write_in;
	// Channel 0..5 differs from last or none known yet
	assign new_inv = (avs_writedata_in[4:2] <= LAST_INV_CHAN) &&
		(!chan_ok_q || (avs_writedata_in[4:2] != last_chan_q));

	// ==========================================================
	// Next-state logic
	// ==========================================================
	always_comb begin
		st_d = st_q;
		op_d = op_q;
		tmr_d = tmr_q + 1'b1;
		word_d = word_q;
		dout_d = dout_q;
		doe_d = doe_q;
		csc_n_d = csc_n_q;
		csa_n_d = csa_n_q;
		we_n_d = we_n_q;
		rd_n_d = rd_n_q;
		rst_n_d = rst_n_q;
		result_d = result_q;
		res_valid_d = res_valid_q;
		res_cnt_d = res_cnt_q;
		discard_d = discard_q;
		disc_en_d = disc_en_q;
		last_chan_d = last_chan_q;
		chan_ok_d = chan_ok_q;
		loop_d = loop_q;
		range_sh_d = range_sh_q;
		ref_sh_d = ref_sh_q;
		dac_sh_d = dac_sh_q;
		// Bus side: writes wait for idle so no command is lost
		ack_d = (avs_read_in | avs_write_in) & ~ack_q &
			(avs_read_in | (st_q == ST_IDLE));
		wait_d = ~ack_d;
		rdata_d = 32'h00000000;
		if (ack_d && avs_read_in) begin
			case (avs_address_in)
				OFS_CTRL: rdata_d = {30'h0, disc_en_q, 1'b0};
				OFS_RANGE: rdata_d = {24'h0, range_sh_q};
				OFS_REF: rdata_d = {24'h0, ref_sh_q};
				OFS_DAC: rdata_d = {24'h0, dac_sh_q};
				OFS_RESULT: rdata_d = {24'h0, result_q};
				OFS_STATUS: rdata_d = {16'h0, res_cnt_q, 5'h0,
					loop_q, res_valid_q, st_q != ST_IDLE};
				default: rdata_d = 32'h00000000;
			endcase
			// Reading the result consumes it; a store below wins
			if (avs_address_in == OFS_RESULT) begin
				res_valid_d = 1'b0;
			end
		end
		case (st_q)
			// Device reset pulse with both selects parked high
			ST_RST: begin
				rst_n_d = 1'b0;
				csc_n_d = 1'b1;
				csa_n_d = 1'b1;
				doe_d = 1'b0;
				if (tmr_q == TMR_W'(RST_CYC - 1)) begin
					rst_n_d = 1'b1;
					st_d = ST_IDLE;
					// Mirror what the device now holds
					range_sh_d = RANGE_RST;
					ref_sh_d = REF_RST;
					dac_sh_d = DAC_RST;
					loop_d = 1'b0;
					chan_ok_d = 1'b0;
				end
			end
			// Wait for a software command
			ST_IDLE: begin
				tmr_d = '0;
				if (cmd) begin
					word_d = avs_writedata_in[7:0];
					dout_d = avs_writedata_in[7:0];
					case (avs_address_in)
						OFS_CTRL: begin
							disc_en_d = avs_writedata_in[CTRL_DISCARD_BIT];
							if (avs_writedata_in[CTRL_RESET_BIT]) begin
								// Drop now so the pulse spans four edges
								rst_n_d = 1'b0;
								st_d = ST_RST;
							end
						end
						OFS_RANGE, OFS_REF: begin
							// Low bits 00 land in the reference register
							if (avs_address_in == OFS_REF ||
								avs_writedata_in[1:0] == 2'b00) begin
								op_d = OP_REF;
								word_d = {avs_writedata_in[7:2], 2'b00};
								dout_d = {avs_writedata_in[7:2], 2'b00};
							end else begin
								op_d = OP_CONV;
								discard_d = disc_en_q & new_inv;
							end
							csc_n_d = 1'b0;
							doe_d = 1'b1;
							we_n_d = 1'b0;
							st_d = ST_WE_LO;
						end
						OFS_DAC: begin
							op_d = OP_DAC;
							csa_n_d = 1'b0;
							doe_d = 1'b1;
							we_n_d = 1'b0;
							st_d = ST_WE_LO;
						end
						default: st_d = ST_IDLE; // Unmapped write ignored
					endcase
				end
			end
			// Strobe low long enough; device latches on the rise
			ST_WE_LO: begin
				if (tmr_q == TMR_W'(WE_CYC - 1)) begin
					we_n_d = 1'b1;
					tmr_d = '0;
					st_d = ST_HOLD;
				end
			end
			// Hold data and select past the rising edge
			ST_HOLD: begin
				if (tmr_q == TMR_W'(HOLD_CYC - 1)) begin
					csc_n_d = 1'b1;
					csa_n_d = 1'b1;
					doe_d = 1'b0;
					tmr_d = '0;
					case (op_q)
						OP_CONV: begin
							range_sh_d = word_q;
							last_chan_d = word_q[CHAN_LSB +: 3];
							chan_ok_d = 1'b1;
							st_d = ST_CONV;
						end
						OP_REF: begin
							ref_sh_d = word_q;
							loop_d = word_q[LOOP_BIT];
							st_d = ST_IDLE;
						end
						default: begin
							dac_sh_d = word_q;
							st_d = ST_DAC;
						end
					endcase
				end
			end
			// Conversion time, then select and read strobe together
			ST_CONV: begin
				if (tmr_q == TMR_W'(CONV_WAIT_CYC - 1)) begin
					csa_n_d = 1'b0;
					rd_n_d = 1'b0;
					tmr_d = '0;
					st_d = ST_RD_LO;
				end
			end
			// Access time plus synchroniser, then sample
			ST_RD_LO: begin
				if (tmr_q == TMR_W'(RD_CYC - 1)) begin
					rd_n_d = 1'b1; // Rising edge fires loopback copy
					tmr_d = '0;
					st_d = ST_RD_REL;
					if (!discard_q) begin
						result_d = rx_data;
						res_valid_d = 1'b1;
						res_cnt_d = res_cnt_q + 1'b1;
					end
					if (loop_q) begin
						dac_sh_d = rx_data;
					end
				end
			end
			// Let the device release the bus before driving again
			ST_RD_REL: begin
				csa_n_d = 1'b1;
				if (tmr_q == TMR_W'(DIS_CYC - 1)) begin
					tmr_d = '0;
					if (discard_q) begin
						// Rewrite same word for a settled conversion
						discard_d = 1'b0;
						csc_n_d = 1'b0;
						doe_d = 1'b1;
						dout_d = word_q;
						we_n_d = 1'b0;
						st_d = ST_WE_LO;
					end else begin
						st_d = ST_IDLE;
					end
				end
			end
			// Give the DAC its internal update time
			ST_DAC: begin
				if (tmr_q == TMR_W'(DAC_CYC - 1)) begin
					st_d = ST_IDLE;
				end
			end
			default: st_d = ST_IDLE;
		endcase
	end

	// ==========================================================
	// Registers; power-up runs a device reset first
	// ==========================================================
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			st_q <= ST_RST;
			op_q <= OP_CONV;
			tmr_q <= '0;
			word_q <= 8'h00;
			dout_q <= 8'h00;
			doe_q <= 1'b0;
			csc_n_q <= 1'b1;
			csa_n_q <= 1'b1;
			we_n_q <= 1'b1;
			rd_n_q <= 1'b1;
			rst_n_q <= 1'b0;
			result_q <= 8'h00;
			res_valid_q <= 1'b0;
			res_cnt_q <= 8'h00;
			discard_q <= 1'b0;
			disc_en_q <= CTRL_DISCARD_RST;
			last_chan_q <= 3'h0;
			chan_ok_q <= 1'b0;
			loop_q <= 1'b0;
			range_sh_q <= RANGE_RST;
			ref_sh_q <= REF_RST;
			dac_sh_q <= DAC_RST;
			ack_q <= 1'b0;
			wait_q <= 1'b1;
			rdata_q <= 32'h00000000;
		end else begin
			st_q <= st_d;
			op_q <= op_d;
			tmr_q <= tmr_d;
			word_q <= word_d;
			dout_q <= dout_d;
			doe_q <= doe_d;
			csc_n_q <= csc_n_d;
			csa_n_q <= csa_n_d;
			we_n_q <= we_n_d;
			rd_n_q <= rd_n_d;
			rst_n_q <= rst_n_d;
			result_q <= result_d;
			res_valid_q <= res_valid_d;
			res_cnt_q <= res_cnt_d;
			discard_q <= discard_d;
			disc_en_q <= disc_en_d;
			last_chan_q <= last_chan_d;
			chan_ok_q <= chan_ok_d;
			loop_q <= loop_d;
			range_sh_q <= range_sh_d;
			ref_sh_q <= ref_sh_d;
			dac_sh_q <= dac_sh_d;
			ack_q <= ack_d;
			wait_q <= wait_d;
			rdata_q <= rdata_d;
		end
	end

	// Pins and bus answers straight from flops
	assign avs_readdata_out = rdata_q;
	assign avs_waitrequest_out = wait_q;
	assign ctrl_select_n_out = csc_n_q;
	assign conv_select_n_out = csa_n_q;
	assign write_strobe_n_out = we_n_q;
	assign read_strobe_n_out = rd_n_q;
	assign dev_reset_n_out = rst_n_q;
	assign bus_data_out = dout_q;
	assign bus_data_oe_out = doe_q;

endmodule

`default_nettype wire

/* design/adh_pkg.sv */
package adh_pkg;

	// ==========================================================
	// Clock and timing, figures in ns, counts derived
	// ==========================================================
	localparam int CLK_NS = 8; // Core clock period
	localparam int WE_LOW_NS = 30; // Least write strobe low time
	localparam int HOLD_NS = 15; // Data hold after strobe rise
	localparam int RST_LOW_NS = 25; // Least device reset pulse
	localparam int CONV_NS = 2500; // Longest conversion time
	localparam int ACCESS_NS = 50; // Read access time, heaviest load
	localparam int DIS_NS = 35; // Bus release after read strobe
	localparam int DAC_NS = 100; // Internal DAC update time
	localparam int SYNC_CYC = 2; // Input synchroniser depth

	// Least times round up to whole cycles
	localparam int WE_CYC = (WE_LOW_NS + CLK_NS - 1) / CLK_NS;
	localparam int HOLD_CYC = (HOLD_NS + CLK_NS - 1) / CLK_NS;
	localparam int RST_CYC = (RST_LOW_NS + CLK_NS - 1) / CLK_NS;
	localparam int CONV_CYC = (CONV_NS + CLK_NS - 1) / CLK_NS;
	localparam int RD_CYC = (ACCESS_NS + CLK_NS - 1) / CLK_NS + SYNC_CYC;
	localparam int DIS_CYC = (DIS_NS + CLK_NS - 1) / CLK_NS;
	localparam int DAC_CYC = (DAC_NS + CLK_NS - 1) / CLK_NS;
	localparam int TMR_W = 9; // Holds the longest count

	// ==========================================================
	// Register map, byte addresses
	// ==========================================================
	localparam logic [4:0] OFS_CTRL = 5'h00;
	localparam logic [4:0] OFS_RANGE = 5'h04;
	localparam logic [4:0] OFS_REF = 5'h08;
	localparam logic [4:0] OFS_DAC = 5'h0C;
	localparam logic [4:0] OFS_RESULT = 5'h10;
	localparam logic [4:0] OFS_STATUS = 5'h14;

	// Control register fields
	localparam int CTRL_RESET_BIT = 0; // Write 1: pulse device reset
	localparam int CTRL_DISCARD_BIT = 1; // Drop first inverting result
	// Device control word fields
	localparam int LOOP_BIT = 6; // Loopback enable in reference word
	localparam int CHAN_LSB = 2; // Channel field low bit
	localparam logic [2:0] LAST_INV_CHAN = 3'h5; // Channels 0..5 invert

	// Device register contents after its reset; host discard enable at power-up
	localparam logic [7:0] RANGE_RST = 8'h00;
	localparam logic [7:0] REF_RST = 8'h00;
	localparam logic [7:0] DAC_RST = 8'h00; // Mid-scale, twos complement
	localparam logic CTRL_DISCARD_RST = 1'b1;

	// ==========================================================
	// Sequencer states and operations
	// ==========================================================
	typedef enum logic [2:0] {
		ST_RST, ST_IDLE, ST_WE_LO, ST_HOLD,
		ST_CONV, ST_RD_LO, ST_RD_REL, ST_DAC
	} adh_state_t;

	typedef enum logic [1:0] {OP_CONV, OP_REF, OP_DAC} adh_op_t;

endpackage

/* design/adh_sync2.sv */
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Two-flop synchroniser for pin inputs
// ==========================================================
module adh_sync2 #(
	parameter int WIDTH = 8
) (
	// Clock and reset
	input wire logic core_clk_in,
	input wire logic nrst_in,
	// Data
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_q; // First stage, read only by second

	// Both stages on every edge
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			meta_q <= '0;
			sync_out <= '0;
		end else begin
			meta_q <= async_in;
			sync_out <= meta_q;
		end
	end

endmodule

`default_nettype wire

/* testbench/adh_dev_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Behavioural model of the converter seen from its pins
// ==========================================================
module adh_dev_model #(
	parameter int CONV_NS_P = 120
) (
	// Clock, only for the floating bus pattern
	input wire logic core_clk_in,
	// Selects, strobes and reset
	input wire logic ctrl_select_n_in,
	input wire logic conv_select_n_in,
	input wire logic write_strobe_n_in,
	input wire logic read_strobe_n_in,
	input wire logic dev_reset_n_in,
	// Host side of the data bus
	input wire logic [7:0] host_data_in,
	input wire logic host_oe_in,
	// Resolved bus level
	output logic [7:0] wire_out
);
	logic [7:0] range_q; // Range and channel word
	logic [7:0] ref_q; // Reference word
	logic [7:0] dac_q; // DAC input
	logic [7:0] result_q = 8'h00; // Last finished conversion
	logic [7:0] float_q = 8'h5A; // Undriven bus, never a stale value
	int conv_count = 0; // Conversions started

	// Result code depends on the channel only
	function automatic logic [7:0] code_of(input logic [2:0] c);
		return 8'h93 ^ {c, c, c[1:0]};
	endfunction

	// Pattern moves each cycle so a late sample is caught
	always @(posedge core_clk_in) float_q <= float_q + 8'h3B;

	// Capture on strobe rise, clear while reset low
	always @(posedge write_strobe_n_in or negedge dev_reset_n_in) begin
		if (!dev_reset_n_in) begin
			range_q <= 8'h00;
			ref_q <= 8'h00;
			dac_q <= 8'h00;
		end else if (!ctrl_select_n_in) begin
			if (host_data_in[1:0] == 2'h0) begin
				ref_q <= host_data_in;
			end else begin
				range_q <= host_data_in;
				conv_count <= conv_count + 1;
				result_q <= #(CONV_NS_P) code_of(host_data_in[4:2]);
			end
		end else if (!conv_select_n_in) begin
			dac_q <= host_data_in;
		end
	end

	// Loopback copies the result on read strobe rise
	always @(posedge read_strobe_n_in) begin
		if (ref_q[6] && dev_reset_n_in)
			dac_q <= result_q;
	end

	// Drivers on only while both read strobe and select are low
	assign wire_out = host_oe_in ? host_data_in :
		(!read_strobe_n_in && !conv_select_n_in) ? result_q : float_q;
endmodule

`default_nettype wire

/* testbench/adh_host_asserts.sv */
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Pin sequence checker
// ==========================================================
module adh_host_chk #(
	parameter int CONV_WAIT_CYC = 313
) (
	// Clock and reset
	input wire logic core_clk_in,
	input wire logic nrst_in,
	// Device pins
	input wire logic ctrl_select_n_out,
	input wire logic conv_select_n_out,
	input wire logic write_strobe_n_out,
	input wire logic read_strobe_n_out,
	input wire logic dev_reset_n_out,
	input wire logic [7:0] bus_data_out,
	input wire logic bus_data_oe_out
);
	localparam int C_LO = CONV_WAIT_CYC + 1;
	localparam int C_HI = CONV_WAIT_CYC + 3;
	logic [15:0] quiet_d, quiet_q; // Cycles left with no read allowed
	logic we_q; // Strobe one cycle ago
	logic ref_wr; // Reference word taken now
	assign ref_wr = write_strobe_n_out && !we_q && !ctrl_select_n_out &&
		(bus_data_out[1:0] == 2'h0);

	// Window covers a full conversion wait
	always_comb begin
		quiet_d = (quiet_q != 16'h0000) ? quiet_q - 16'h0001 : 16'h0000;
		if (ref_wr)
			quiet_d = 16'(CONV_WAIT_CYC + 4);
	end
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			quiet_q <= 16'h0000;
			we_q <= 1'b1;
		end else begin
			quiet_q <= quiet_d;
			we_q <= write_strobe_n_out;
		end
	end

	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!nrst_in);

	a_oe_no_read: assert property (bus_data_oe_out |-> read_strobe_n_out)
		else $error("host drives bus in read");
	a_sel_in_reset: assert property (!dev_reset_n_out |->
		ctrl_select_n_out && conv_select_n_out)
		else $error("select low in device reset");
	a_we_pulse: assert property ($fell(write_strobe_n_out) |->
		!write_strobe_n_out [*4] ##1 write_strobe_n_out)
		else $error("write strobe width");
	a_we_select: assert property (!write_strobe_n_out |->
		(ctrl_select_n_out != conv_select_n_out) && bus_data_oe_out)
		else $error("write without one select");
	a_we_hold: assert property ($rose(write_strobe_n_out) |->
		$stable(bus_data_out) && bus_data_oe_out && $stable(ctrl_select_n_out))
		else $error("data moved at strobe rise");
	a_rd_pulse: assert property ($fell(read_strobe_n_out) |->
		##1 !read_strobe_n_out [*8] ##1 read_strobe_n_out)
		else $error("read strobe width");
	a_rd_select: assert property (!read_strobe_n_out |->
		!conv_select_n_out && ctrl_select_n_out)
		else $error("read without converter select");
	a_conv_start: assert property ($rose(write_strobe_n_out) &&
		!ctrl_select_n_out && (bus_data_out[1:0] != 2'h0) |->
		##[C_LO:C_HI] $fell(read_strobe_n_out))
		else $error("no result read after range write");
	a_ref_quiet: assert property (quiet_q != 16'h0000 |-> read_strobe_n_out)
		else $error("read after reference write");
endmodule

bind adh_host adh_host_chk #(.CONV_WAIT_CYC(CONV_WAIT_CYC)) adh_host_chk_inst (
	.core_clk_in(core_clk_in), .nrst_in(nrst_in),
	.ctrl_select_n_out(ctrl_select_n_out),
	.conv_select_n_out(conv_select_n_out),
	.write_strobe_n_out(write_strobe_n_out),
	.read_strobe_n_out(read_strobe_n_out), .dev_reset_n_out(dev_reset_n_out),
	.bus_data_out(bus_data_out), .bus_data_oe_out(bus_data_oe_out)
);

`default_nettype wire

/* testbench/test_adh_host.sv */
`timescale 1ns/1ps
`default_nettype none

`define CHK(g, e) begin \
	cmp_count++; \
	if ((g) !== (e)) begin \
		n_errors++; \
		$display("BAD t=%0t got %h exp %h", $time, (g), (e)); \
	end \
end

// ==========================================================
// Bench: Avalon master, converter model, read monitor
// ==========================================================
module test_adh_host;
	import adh_pkg::*;
	localparam int CW = 20; // Short conversion wait
	logic core_clk_in = 1'b0;
	logic nrst_in = 1'b0;
	logic [4:0] av_addr = 5'h00;
	logic av_rd = 1'b0;
	logic av_wr = 1'b0;
	logic [31:0] av_wdata = 32'h0;
	logic [31:0] av_rdata;
	logic av_wait, csel_n, vsel_n, we_n, rd_n, drst_n, hoe;
	logic [7:0] hdata, wire_v;
	logic [23:0] dev_regs; // Model registers: range, ref, dac
	logic [31:0] exp_q[$]; // Expected read data, oldest first
	logic chk_rd = 1'b0; // Current read is compared
	int n_errors = 0;
	int cmp_count = 0;

	always #4 core_clk_in = ~core_clk_in;

	adh_host #(.CONV_WAIT_CYC(CW)) adh_host_inst (
		.core_clk_in(core_clk_in), .nrst_in(nrst_in),
		.avs_address_in(av_addr), .avs_read_in(av_rd), .avs_write_in(av_wr),
		.avs_writedata_in(av_wdata), .avs_readdata_out(av_rdata),
		.avs_waitrequest_out(av_wait), .ctrl_select_n_out(csel_n),
		.conv_select_n_out(vsel_n), .write_strobe_n_out(we_n),
		.read_strobe_n_out(rd_n), .dev_reset_n_out(drst_n),
		.bus_data_in(wire_v), .bus_data_out(hdata), .bus_data_oe_out(hoe)
	);
	adh_dev_model adh_dev_model_inst (
		.core_clk_in(core_clk_in), .ctrl_select_n_in(csel_n),
		.conv_select_n_in(vsel_n), .write_strobe_n_in(we_n),
		.read_strobe_n_in(rd_n), .dev_reset_n_in(drst_n),
		.host_data_in(hdata), .host_oe_in(hoe), .wire_out(wire_v)
	);
	assign dev_regs = {adh_dev_model_inst.range_q, adh_dev_model_inst.ref_q,
		adh_dev_model_inst.dac_q};

	function automatic logic [7:0] code(input logic [2:0] c);
		return 8'h93 ^ {c, c, c[1:0]};
	endfunction

	task automatic results();
		$display("comparisons %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// One access, held until waitrequest is seen low
	task automatic av_cycle(input logic w, input logic [4:0] a,
		input logic [31:0] d, input logic c, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge core_clk_in);
		av_addr <= a;
		av_wdata <= d;
		av_wr <= w;
		av_rd <= !w;
		chk_rd <= c;
		do begin
			@(posedge core_clk_in);
			n++;
		end while (av_wait !== 1'b0 && n < 3000);
		q = av_rdata;
		av_wr <= 1'b0;
		av_rd <= 1'b0;
		chk_rd <= 1'b0;
		if (n >= 3000) begin
			n_errors++;
			results();
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		logic [31:0] q;
		av_cycle(1'b1, a, d, 1'b0, q);
	endtask
	task automatic rd_exp(input logic [4:0] a, input logic [31:0] e);
		logic [31:0] q;
		exp_q.push_back(e);
		av_cycle(1'b0, a, 32'h0, 1'b1, q);
	endtask
	// Poll busy, bounded
	task automatic wait_idle();
		logic [31:0] q;
		int n;
		n = 0;
		do begin
			av_cycle(1'b0, OFS_STATUS, 32'h0, 1'b0, q);
			n++;
		end while (q[0] !== 1'b0 && n < 2000);
		if (n >= 2000) begin
			n_errors++;
			results();
		end
	endtask

	// Compare each checked read against the oldest note
	always @(posedge core_clk_in) begin
		if (av_rd && !av_wait && chk_rd)
			`CHK(av_rdata, exp_q.pop_front())
	end

	initial begin
		logic [7:0] w;
		int c0;
		c0 = $urandom(12);
		repeat (4) @(posedge core_clk_in);
		nrst_in <= 1'b1;
		wait_idle();
		`CHK(dev_regs, 24'h000000)
		rd_exp(OFS_RANGE, 32'h0);
		rd_exp(OFS_DAC, 32'h0);
		rd_exp(5'h18, 32'h0);
		$display("reset test done");
		wr(OFS_CTRL, 32'h0);
		for (int ch = 0; ch < 8; ch++) begin
			w = {3'($urandom), 3'(ch), 2'($urandom_range(3, 1))};
			c0 = adh_dev_model_inst.conv_count;
			wr(OFS_RANGE, {24'h0, w});
			wait_idle();
			`CHK(dev_regs[23:16], w)
			`CHK(adh_dev_model_inst.conv_count, c0 + 1)
			rd_exp(OFS_RESULT, {24'h0, code(3'(ch))});
			rd_exp(OFS_RESULT, {24'h0, code(3'(ch))});
		end
		$display("channel test done");
		c0 = adh_dev_model_inst.conv_count;
		wr(OFS_RANGE, 32'h28);
		w = {3'b010, 3'($urandom), 2'b00};
		wr(OFS_REF, {24'h0, w});
		wr(OFS_RANGE, 32'h1D);
		wait_idle();
		`CHK(dev_regs[15:8], w)
		`CHK(adh_dev_model_inst.conv_count, c0 + 1)
		`CHK(dev_regs[7:0], code(3'h7))
		rd_exp(OFS_DAC, {24'h0, code(3'h7)});
		rd_exp(OFS_STATUS, 32'h00000906);
		$display("loopback test done");
		w = 8'($urandom);
		wr(OFS_REF, 32'h0);
		wr(OFS_DAC, {24'h0, w});
		wait_idle();
		`CHK(dev_regs[7:0], w)
		rd_exp(OFS_DAC, {24'h0, w});
		$display("dac test done");
		wr(OFS_CTRL, 32'h2);
		for (int k = 2; k > 0; k--) begin
			c0 = adh_dev_model_inst.conv_count;
			wr(OFS_RANGE, 32'h0D);
			wait_idle();
			`CHK(adh_dev_model_inst.conv_count, c0 + k)
			rd_exp(OFS_RESULT, {24'h0, code(3'h3)});
		end
		$display("discard test done");
		wr(OFS_CTRL, 32'h1);
		wait_idle();
		`CHK(dev_regs, 24'h000000)
		rd_exp(OFS_REF, 32'h0);
		$display("device reset test done");
		results();
	end
endmodule

`default_nettype wire
